//--- verilog/rtcsub_cfg.svh
// constants for the seconds base of the real-time counter
// assumes one 50 MHz system clock and a CPU-side byte-addressed bus
`ifndef RTCSUB_CFG_SVH
`define RTCSUB_CFG_SVH

// ====================================================================
// register map
`define RTCSUB_SUB_OFS      20'h0_FFF90
`define RTCSUB_SEC_OFS      20'h0_FFF92
`define RTCSUB_SUB_RST      16'h0000
`define RTCSUB_SEC_RST      7'h00

// ====================================================================
// field layout of the seconds register
`define RTCSUB_UNITS_LSB    0
`define RTCSUB_UNITS_MSB    3
`define RTCSUB_TENS_LSB     4
`define RTCSUB_TENS_MSB     6
`define RTCSUB_UNITS_MAX    4'h9
`define RTCSUB_TENS_MAX     3'h5

// ====================================================================
// sub-second counter range and rate trim
`define RTCSUB_SUB_TOP      16'h7FFF
`define RTCSUB_TRIM_UP_BIT  7

// ====================================================================
// timing
`define RTCSUB_CLK_HZ       50000000
`define RTCSUB_CNT_HZ       32768
`define RTCSUB_XFER_PERIODS 2
`define RTCSUB_XFER_CYCLES  ((`RTCSUB_XFER_PERIODS * `RTCSUB_CLK_HZ) / `RTCSUB_CNT_HZ)
`define RTCSUB_FIX_PERIODS  1
`define RTCSUB_FIX_CYCLES   ((`RTCSUB_FIX_PERIODS * `RTCSUB_CLK_HZ) / `RTCSUB_CNT_HZ)

`endif

//--- verilog/rtcsub_pkg.sv
// types shared by the seconds base of the real-time counter
// assumes nothing of its surroundings
`default_nettype none

package rtcsub_pkg;

	// state of the seconds write buffer
	typedef enum logic {
		RTCSUB_BUF_IDLE,
		RTCSUB_BUF_PEND
	} rtcsub_buf_t;

	// seconds value without the always-zero top bit
	typedef logic [6:0] rtcsub_bcd_t;

endpackage

`default_nettype wire

//--- verilog/rtcsub_sec_if.sv
// link between the sub-second logic and the seconds counter
// assumes both ends run on ref_clk
`timescale 1ns/1ns
`default_nettype none

interface rtcsub_sec_if;
	logic                   clkEn;
	logic                   tick;
	logic                   overflow;
	logic                   load;
	rtcsub_pkg::rtcsub_bcd_t loadValue;
	rtcsub_pkg::rtcsub_bcd_t secValue;
	logic                   carry;

	modport ctrl (
		output clkEn,
		output tick,
		output overflow,
		output load,
		output loadValue,
		input  secValue,
		input  carry
	);

	modport counter (
		input  clkEn,
		input  tick,
		input  overflow,
		input  load,
		input  loadValue,
		output secValue,
		output carry
	);
endinterface

`default_nettype wire

//--- verilog/rtcsub_sec_counter.sv
// bcd seconds counter, 00 to 59, with buffered load and carry out
// assumes tick is a one-cycle pulse per count-clock period
`timescale 1ns/1ns
`default_nettype none
`include "rtcsub_cfg.svh"

module rtcsub_sec_counter (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	rtcsub_sec_if.counter     secIf
);

	rtcsub_pkg::rtcsub_bcd_t secCount_reg;
	rtcsub_pkg::rtcsub_bcd_t secCount_next;
	logic                    carry_reg;
	logic                    carry_next;
	logic [3:0]              units;
	logic [2:0]              tens;
	logic                    valid;

	assign units = secCount_reg[`RTCSUB_UNITS_MSB:`RTCSUB_UNITS_LSB];
	assign tens  = secCount_reg[`RTCSUB_TENS_MSB:`RTCSUB_TENS_LSB];
	assign valid = (units <= `RTCSUB_UNITS_MAX) && (tens <= `RTCSUB_TENS_MAX);

	// ====================================================================
	// next value
	always_comb begin
		secCount_next = secCount_reg;
		carry_next    = 1'b0;
		if (secIf.tick) begin
			if (secIf.load) begin
				secCount_next = secIf.loadValue;
			end else if (!valid) begin
				secCount_next = `RTCSUB_SEC_RST;
			end else if (secIf.overflow) begin
				if (units == `RTCSUB_UNITS_MAX) begin
					if (tens == `RTCSUB_TENS_MAX) begin
						secCount_next = `RTCSUB_SEC_RST;
						carry_next    = 1'b1;
					end else begin
						secCount_next = {tens + 3'h1, 4'h0};
					end
				end else begin
					secCount_next = {tens, units + 4'h1};
				end
			end
		end
	end

	// ====================================================================
	// state
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			secCount_reg <= `RTCSUB_SEC_RST;
		end else if (secIf.clkEn) begin
			secCount_reg <= secCount_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			carry_reg <= 1'b0;
		end else if (secIf.clkEn) begin
			carry_reg <= carry_next;
		end
	end

	assign secIf.secValue = secCount_reg;
	assign secIf.carry    = carry_reg;

endmodule

`default_nettype wire

//--- verilog/rtcsub_top.sv
// seconds base of the real-time counter: sub-second counter,
// seconds write buffer and register read-back
// assumes a synchronous CPU-side bus with byte addresses and a
// 50 MHz ref_clk from which the 32.768 kHz count tick is derived
`timescale 1ns/1ns
`default_nettype none
`include "rtcsub_cfg.svh"

module rtcsub_top #(
	parameter int ADDR_W = 20,
	parameter int CLK_HZ = `RTCSUB_CLK_HZ,
	parameter int CNT_HZ = `RTCSUB_CNT_HZ
) (
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              clkEn,
	input  wire logic [ADDR_W-1:0] busAddr,
	input  wire logic              busWr,
	input  wire logic              busRd,
	input  wire logic              busWide,
	input  wire logic [15:0]       busWdata,
	output logic      [15:0]       busRdata,
	output logic                   busRvalid,
	input  wire logic [7:0]        rate_trim_setting,
	output logic      [15:0]       sub_second_count,
	output logic      [7:0]        whole_second_count,
	output logic                   secCarry
);

	localparam int ACC_W = 27;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CNT_HZ);
	localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);

	rtcsub_sec_if secIf ();

	// ====================================================================
	// count tick: fractional divider from ref_clk to 32.768 kHz
	logic [ACC_W-1:0] phase_reg;
	logic [ACC_W-1:0] phase_next;
	logic [ACC_W-1:0] phaseSum;
	logic             cntTick;

	// remainder carries over, so the tick rate never drifts
	assign phaseSum = phase_reg + ACC_STEP;
	assign cntTick  = (phaseSum >= ACC_WRAP);

	always_comb begin
		phase_next = phaseSum;
		if (cntTick) begin
			phase_next = phaseSum - ACC_WRAP;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			phase_reg <= '0;
		end else if (clkEn) begin
			phase_reg <= phase_next;
		end
	end

	// ====================================================================
	// bus decode
	logic subHit;
	logic secHit;
	logic secWrite;

	assign subHit   = (busAddr == ADDR_W'(`RTCSUB_SUB_OFS)) && busWide;
	assign secHit   = (busAddr == ADDR_W'(`RTCSUB_SEC_OFS)) && !busWide;
	assign secWrite = busWr && secHit;

	// ====================================================================
	// sub-second counter with rate trim
	logic [15:0] subCount_reg;
	logic [15:0] subCount_next;
	logic [15:0] subLimit;
	logic [15:0] trimMag;
	logic        subOverflow;

	assign trimMag = {9'h000, rate_trim_setting[6:0]};

	always_comb begin
		if (rate_trim_setting[`RTCSUB_TRIM_UP_BIT]) begin
			subLimit = `RTCSUB_SUB_TOP + trimMag;
		end else begin
			subLimit = `RTCSUB_SUB_TOP - trimMag;
		end
	end

	// compare with >= so a trim step down never strands the count above the top
	assign subOverflow = cntTick && (subCount_reg >= subLimit);

	always_comb begin
		subCount_next = subCount_reg;
		if (secWrite) begin
			subCount_next = `RTCSUB_SUB_RST;
		end else if (subOverflow) begin
			subCount_next = `RTCSUB_SUB_RST;
		end else if (cntTick) begin
			subCount_next = subCount_reg + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			subCount_reg <= `RTCSUB_SUB_RST;
		end else if (clkEn) begin
			subCount_reg <= subCount_next;
		end
	end

	// ====================================================================
	// seconds write buffer
	rtcsub_pkg::rtcsub_buf_t bufState_reg;
	rtcsub_pkg::rtcsub_buf_t bufState_next;
	rtcsub_pkg::rtcsub_bcd_t secBuf_reg;

	// data bits 7 and up dropped, so bit 7 always reads zero
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			secBuf_reg <= `RTCSUB_SEC_RST;
		end else if (clkEn && secWrite) begin
			secBuf_reg <= busWdata[6:0];
		end
	end

	always_comb begin
		bufState_next = bufState_reg;
		case (bufState_reg)
			rtcsub_pkg::RTCSUB_BUF_IDLE: begin
				if (secWrite) begin
					bufState_next = rtcsub_pkg::RTCSUB_BUF_PEND;
				end
			end
			rtcsub_pkg::RTCSUB_BUF_PEND: begin
				if (cntTick && !secWrite) begin
					bufState_next = rtcsub_pkg::RTCSUB_BUF_IDLE;
				end
			end
			default: begin
				bufState_next = rtcsub_pkg::RTCSUB_BUF_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bufState_reg <= rtcsub_pkg::RTCSUB_BUF_IDLE;
		end else if (clkEn) begin
			bufState_reg <= bufState_next;
		end
	end

	// ====================================================================
	// seconds counter
	assign secIf.clkEn     = clkEn;
	assign secIf.tick      = cntTick;
	assign secIf.overflow  = subOverflow;
	// a write in the tick cycle defers the load, so the newest data wins
	assign secIf.load      = (bufState_reg == rtcsub_pkg::RTCSUB_BUF_PEND) && !secWrite;
	assign secIf.loadValue = secBuf_reg;

	rtcsub_sec_counter rtcsub_sec_counter_i (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.secIf   (secIf)
	);

	// ====================================================================
	// register read-back
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic        rvalid_reg;

	// wrong-width or unmapped reads answer zero
	always_comb begin
		rdata_next = 16'h0000;
		if (subHit) begin
			rdata_next = subCount_reg;
		end else if (secHit) begin
			rdata_next = {9'h000, secIf.secValue};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rdata_reg <= 16'h0000;
		end else if (clkEn && busRd) begin
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rvalid_reg <= 1'b0;
		end else if (clkEn) begin
			rvalid_reg <= busRd;
		end
	end

	assign busRdata           = rdata_reg;
	assign busRvalid          = rvalid_reg;
	assign sub_second_count   = subCount_reg;
	assign whole_second_count = {1'b0, secIf.secValue};
	assign secCarry           = secIf.carry;

endmodule

`default_nettype wire

//--- verif/rtcsub_top_sva.sv
// checker for the seconds base of the real-time counter
// assumes a bind onto rtcsub_top and the single ref_clk domain
`timescale 1ns/1ns
`default_nettype none
`include "rtcsub_cfg.svh"

module rtcsub_top_sva #(
	parameter int ADDR_W = 20,
	parameter int CLK_HZ = 50000000,
	parameter int CNT_HZ = 32768
) (
	input wire logic              ref_clk,
	input wire logic              rstn,
	input wire logic              clkEn,
	input wire logic [ADDR_W-1:0] busAddr,
	input wire logic              busWr,
	input wire logic              busWide,
	input wire logic [15:0]       busWdata,
	input wire logic [7:0]        rate_trim_setting,
	input wire logic [15:0]       sub_second_count,
	input wire logic [7:0]        whole_second_count,
	input wire logic              secCarry
);
	// slack of two system cycles on top of the count periods
	localparam int XFER = 2 * (CLK_HZ / CNT_HZ) + 2;
	localparam int FIX  = CLK_HZ / CNT_HZ + 2;
	logic secWr;
	logic secBad;
	assign secWr = clkEn && busWr && !busWide && busAddr == ADDR_W'(`RTCSUB_SEC_OFS);
	assign secBad = whole_second_count[3:0] > 4'h9 || whole_second_count[6:4] > 3'h5;
	// enabled cycles since a valid seconds write, and since a bad value showed
	logic [15:0] xferAge;
	logic [15:0] fixAge;
	logic [6:0]  xferVal;
	logic        xferOn;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			xferOn  <= 1'b0;
			xferAge <= 16'h0000;
			xferVal <= 7'h00;
		end else if (secWr) begin
			xferOn  <= (busWdata[3:0] <= 4'h9) && (busWdata[6:4] <= 3'h5);
			xferAge <= 16'h0000;
			xferVal <= busWdata[6:0];
		end else if (xferOn && (whole_second_count == {1'b0, xferVal})) begin
			xferOn <= 1'b0;
		end else if (xferOn && clkEn) begin
			xferAge <= xferAge + 16'h0001;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn || !secBad) begin
			fixAge <= 16'h0000;
		end else if (clkEn) begin
			fixAge <= fixAge + 16'h0001;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking

	// ====================================================================
	// properties
	property p_sub_rst;
		!rstn |=> sub_second_count == 16'h0000;
	endproperty
	a_sub_rst: assert property (p_sub_rst) else $error("sub count not cleared by reset");
	property p_sec_rst;
		!rstn |=> whole_second_count == 8'h00;
	endproperty
	a_sec_rst: assert property (p_sec_rst) else $error("seconds not cleared by reset");
	property p_bit7;
		disable iff (!rstn) whole_second_count[7] == 1'b0;
	endproperty
	a_bit7: assert property (p_bit7) else $error("seconds bit 7 set");
	property p_wr_clr;
		disable iff (!rstn) secWr |=> sub_second_count == 16'h0000;
	endproperty
	a_wr_clr: assert property (p_wr_clr) else $error("sub count kept on write");
	property p_xfer;
		disable iff (!rstn) xferOn |-> xferAge <= 16'(XFER);
	endproperty
	a_xfer: assert property (p_xfer) else $error("seconds write not loaded in time");
	property p_fix;
		disable iff (!rstn) secBad |-> fixAge <= 16'(FIX);
	endproperty
	a_fix: assert property (p_fix) else $error("bad seconds value not corrected");
	property p_top;
		disable iff (!rstn) !rate_trim_setting[7] |-> sub_second_count <= 16'h7FFF;
	endproperty
	a_top: assert property (p_top) else $error("sub count above normal range");
	property p_inc;
		disable iff (!rstn) $past(sub_second_count) >= 16'h7F00 && sub_second_count == 16'h0000
			&& !$past(secWr) |-> whole_second_count != $past(whole_second_count);
	endproperty
	a_inc: assert property (p_inc) else $error("seconds not advanced on overflow");
	property p_roll;
		disable iff (!rstn) $past(whole_second_count) == 8'h59 && whole_second_count == 8'h00
			|-> ##[0:1] secCarry;
	endproperty
	a_roll: assert property (p_roll) else $error("no carry on roll");
	property p_carry;
		disable iff (!rstn) secCarry |-> whole_second_count == 8'h00 ##1 !secCarry;
	endproperty
	a_carry: assert property (p_carry) else $error("carry wrong or too long");
	property p_freeze;
		disable iff (!rstn) !clkEn |=> $stable(sub_second_count) && $stable(whole_second_count);
	endproperty
	a_freeze: assert property (p_freeze) else $error("count moved with clock enable low");
endmodule

`default_nettype wire

//--- verif/rtcsub_top_bench.sv
// self-checking bench for the seconds base of the real-time counter
// assumes the count tick runs at the system clock rate to keep seconds short
`timescale 1ns/1ns
`default_nettype none
`include "rtcsub_cfg.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module rtcsub_top_bench;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        clkEn = 1'b1;
	logic [19:0] busAddr = '0;
	logic        busWr = 1'b0;
	logic        busRd = 1'b0;
	logic        busWide = 1'b0;
	logic [15:0] busWdata = '0;
	logic [7:0]  trim = '0;
	logic [15:0] busRdata;
	logic [15:0] subCnt;
	logic [7:0]  secCnt;
	logic        busRvalid;
	logic        secCarry;
	logic [15:0] maxSub = '0;
	logic [15:0] frozen = '0;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;

	rtcsub_top #(.CNT_HZ(`RTCSUB_CLK_HZ)) rtcsub_top_i (
		.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .busAddr(busAddr),
		.busWr(busWr), .busRd(busRd), .busWide(busWide), .busWdata(busWdata),
		.busRdata(busRdata), .busRvalid(busRvalid), .rate_trim_setting(trim),
		.sub_second_count(subCnt), .whole_second_count(secCnt), .secCarry(secCarry)
	);

	// ====================================================================
	// clock, peak tracking and hang guard (two seconds need about 66000)
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		maxSub <= (subCnt > maxSub) ? subCnt : maxSub;
		if (cycles == 80000) begin
			mismatches++;
			stop_test();
		end
	end

	// ====================================================================
	// bus tasks
	task automatic wr8(input logic [19:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		busAddr = a;
		busWide = 1'b0;
		busWdata = {8'h00, d};
		busWr = 1'b1;
		@(posedge ref_clk);
		#1;
		busWr = 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, input logic w, input logic [15:0] ex,
		input logic chk);
		@(posedge ref_clk);
		#1;
		busAddr = a;
		busWide = w;
		busRd = 1'b1;
		@(posedge ref_clk);
		#1;
		busRd = 1'b0;
		`CHK("busRvalid", 1'b1, busRvalid)
		if (chk) begin
			`CHK("busRdata", ex, busRdata)
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ====================================================================
	// tests
	initial begin
		repeat (20) @(posedge ref_clk);
		#1;
		`CHK("sub_second_count", 16'h0000, subCnt)
		`CHK("whole_second_count", 8'h00, secCnt)
		rstn = 1'b1;
		rd(`RTCSUB_SEC_OFS, 1'b0, 16'h0000, 1'b1);
		$display("test reset done");
		wr8(`RTCSUB_SEC_OFS, 8'h37);
		`CHK("subCleared", 1'b1, subCnt < 16'h0004)
		repeat (4) @(posedge ref_clk);
		rd(`RTCSUB_SEC_OFS, 1'b0, 16'h0037, 1'b1);
		rd(`RTCSUB_SEC_OFS, 1'b1, 16'h0000, 1'b1);
		rd(20'h0_FFF94, 1'b0, 16'h0000, 1'b1);
		rd(`RTCSUB_SUB_OFS, 1'b1, 16'h0000, 1'b0);
		$display("test write done");
		rstn = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("sub_second_count", 16'h0000, subCnt)
		`CHK("whole_second_count", 8'h00, secCnt)
		rstn = 1'b1;
		$display("test mid-run reset done");
		frozen = subCnt;
		clkEn = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK("frozen", frozen, subCnt)
		clkEn = 1'b1;
		$display("test freeze done");
		wr8(`RTCSUB_SEC_OFS, 8'h7A);
		repeat (4) @(posedge ref_clk);
		rd(`RTCSUB_SEC_OFS, 1'b0, 16'h0000, 1'b1);
		$display("test invalid done");
		trim = 8'h7F;
		wr8(`RTCSUB_SEC_OFS, 8'h59);
		for (int i = 0; i < 33000 && secCarry !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK("secCarry", 1'b1, secCarry)
		`CHK("whole_second_count", 8'h00, secCnt)
		`CHK("maxSub", 16'h7F80, maxSub)
		$display("test roll done");
		trim = 8'h81;
		wr8(`RTCSUB_SEC_OFS, 8'h00);
		for (int i = 0; i < 33000 && subCnt <= 16'h7FFF; i++) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK("sub_second_count", 16'h8000, subCnt)
		$display("test trim done");
		stop_test();
	end
endmodule

bind rtcsub_top rtcsub_top_sva #(.ADDR_W(ADDR_W), .CLK_HZ(CLK_HZ), .CNT_HZ(CNT_HZ)) rtcsub_top_sva_i (
	.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .busAddr(busAddr), .busWr(busWr),
	.busWide(busWide), .busWdata(busWdata), .rate_trim_setting(rate_trim_setting),
	.sub_second_count(sub_second_count), .whole_second_count(whole_second_count),
	.secCarry(secCarry)
);

`default_nettype wire
